// File: shared/fsg_pkg.sv
/*
 package for the flash protection host controller: register map, pin codes,
 command words, timing counts.
 assumes a 50 MHz system clock and a 16-bit word-mode flash bus.
*/
package fsg_pkg;
	// wishbone register offsets (byte addresses)
	localparam logic [3:0] REG_CTRL    = 4'h0;
	localparam logic [3:0] REG_ADDR    = 4'h4;
	localparam logic [3:0] REG_DATA    = 4'h8;
	localparam logic [3:0] REG_STATUS  = 4'hc;
	// control fields
	localparam int CTRL_GO      = 0;
	localparam int CTRL_OP_LSB  = 1;
	localparam int CTRL_OP_W    = 3;
	localparam int CTRL_PA_LSB  = 4;
	localparam int CTRL_HV      = 6;
	localparam int CTRL_PWR     = 7;
	// status fields
	localparam int ST_BUSY      = 0;
	localparam int ST_REFUSED   = 1;
	localparam int ST_SEC       = 2;
	localparam int ST_IND_LSB   = 8;
	// operations
	localparam logic [2:0] OP_READ     = 3'h0;
	localparam logic [2:0] OP_WRITE    = 3'h1;
	localparam logic [2:0] OP_PROGRAM  = 3'h2;
	localparam logic [2:0] OP_SEC_ENT  = 3'h3;
	localparam logic [2:0] OP_SEC_EXIT = 3'h4;
	localparam logic [2:0] OP_RESET    = 3'h5;
	// protect/accel pin level codes
	localparam logic [1:0] PA_LOW  = 2'h0;
	localparam logic [1:0] PA_HIGH = 2'h1;
	localparam logic [1:0] PA_ACC  = 2'h2;
	// reset pin level codes
	localparam logic [1:0] RP_LOW  = 2'h0;
	localparam logic [1:0] RP_HIGH = 2'h1;
	localparam logic [1:0] RP_HV   = 2'h2;
	// command cycles, word mode
	localparam logic [21:0] UNLOCK_A1 = 22'h000555;
	localparam logic [21:0] UNLOCK_A2 = 22'h0002aa;
	localparam logic [15:0] UNLOCK_D1 = 16'h00aa;
	localparam logic [15:0] UNLOCK_D2 = 16'h0055;
	localparam logic [15:0] CMD_PROG  = 16'h00a0;
	localparam logic [15:0] CMD_SENT  = 16'h0088;
	localparam logic [15:0] CMD_SEXIT = 16'h0090;
	localparam logic [15:0] CMD_SEX2  = 16'h0000;
	localparam logic [15:0] CMD_RST   = 16'h00f0;
	// secured-region indicator values
	localparam logic [7:0] IND_FACTORY  = 8'h81;
	localparam logic [7:0] IND_CUSTOMER = 8'h41;
	localparam logic [7:0] IND_NONE     = 8'h01;
	// boot sector numbers guarded by the protect pin
	localparam int BOOT_SA0 = 0;
	localparam int BOOT_SA1 = 1;
	localparam int BOOT_SA2 = 140;
	localparam int BOOT_SA3 = 141;
	// sector map: eight small sectors at each end, one large per upper-bits value
	localparam int SEC_LSB  = 12;
	localparam int BLK_LSB  = 15;
	localparam int BLK_BASE = 7;
	localparam int TOP_BASE = 134;
	// timing
	localparam int CLK_MHZ     = 50;
	localparam int GLITCH_NS   = 5;
	localparam int STROBE_NS   = 60;
	localparam int STROBE_CYC  = (STROBE_NS * CLK_MHZ + 999) / 1000;
	localparam int GLITCH_CYC  = (GLITCH_NS * CLK_MHZ + 999) / 1000;
	localparam int PULSE_CYC   = (STROBE_CYC > GLITCH_CYC) ? STROBE_CYC : GLITCH_CYC;
	localparam int CNT_W       = 4;
endpackage

// File: src/fsg_strobe.sv
/*
 one flash bus cycle: drives chip, write and output enables for a read or a write.
 assumes the caller holds address and data stable while busy.
*/
`timescale 1ns/1ps
module fsg_strobe
(
	// clock and reset
	input  wire  logic        sys_clk_i,
	input  wire  logic        srst_i,
	// request
	input  wire  logic        start_i,
	input  wire  logic        write_i,
	input  wire  logic        inhibit_i,
	output logic              done_o,
	// strobes, active low; data drive enable, active high
	output logic              ce_n_o,
	output logic              we_n_o,
	output logic              oe_n_o,
	output logic              dq_oe_o
);
	logic [fsg_pkg::CNT_W-1:0] cnt_reg;
	logic                      busy_reg;

	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			busy_reg <= 1'b0;
			cnt_reg  <= '0;
			done_o   <= 1'b0;
			ce_n_o   <= 1'b1;
			we_n_o   <= 1'b1;
			oe_n_o   <= 1'b1;
			dq_oe_o  <= 1'b0;
		end
		else if (!busy_reg)
		begin
			done_o <= 1'b0;
			if (start_i && !(write_i && inhibit_i))
			begin
				busy_reg <= 1'b1;
				cnt_reg  <= fsg_pkg::CNT_W'(fsg_pkg::PULSE_CYC);
				ce_n_o   <= 1'b0;
				// write: ce and we low with oe high
				we_n_o   <= !write_i;
				oe_n_o   <= write_i;
				dq_oe_o  <= write_i;
			end
			else if (start_i)
				done_o <= 1'b1;
		end
		else if (cnt_reg != '0)
			// pulse held well beyond the glitch filter width
			cnt_reg <= cnt_reg - 1'b1;
		else
		begin
			busy_reg <= 1'b0;
			done_o   <= 1'b1;
			ce_n_o   <= 1'b1;
			we_n_o   <= 1'b1;
			oe_n_o   <= 1'b1;
			dq_oe_o  <= 1'b0;
		end
	end
endmodule // fsg_strobe

// File: src/fsg_guard.sv
/*
 host-side protection predictor: says whether a program to a sector would be
 refused, given pin levels, secured mode and the host's image of stored protection.
 assumes sector number is already decoded from the address.
*/
`timescale 1ns/1ps
module fsg_guard
(
	// inputs
	input  wire  logic [7:0]  sector_i,
	input  wire  logic [1:0]  pa_level_i,
	input  wire  logic        hv_reset_i,
	input  wire  logic        stored_prot_i,
	input  wire  logic        secured_i,
	input  wire  logic [7:0]  ind_i,
	// result
	output logic              refuse_o
);
	logic boot;
	always_comb
	begin
		boot = (sector_i == 8'(fsg_pkg::BOOT_SA0)) || (sector_i == 8'(fsg_pkg::BOOT_SA1)) ||
		       (sector_i == 8'(fsg_pkg::BOOT_SA2)) || (sector_i == 8'(fsg_pkg::BOOT_SA3));
		refuse_o = 1'b0;
		if (secured_i)
			// locked region never modifiable
			refuse_o = (ind_i != fsg_pkg::IND_NONE);
		else if (boot && pa_level_i == fsg_pkg::PA_LOW)
			// boot sectors locked by low pin, also in temporary unprotect
			refuse_o = 1'b1;
		else if (stored_prot_i && !hv_reset_i)
			// stored state rules unless high voltage on reset
			refuse_o = 1'b1;
	end
endmodule // fsg_guard

// File: src/fsg_host.sv
/*
 host controller for a protected nor flash: wishbone register slave, command
 sequencer, pin level control for the protect/accel and reset pins.
 assumes the flash is in word mode and outside analog drivers turn level codes
 into real voltages.
*/
// Added by the designer: the Wishbone register port and the address map.
`timescale 1ns/1ps
module fsg_host
(
	// clock and reset
	input  wire  logic        sys_clk_i,
	input  wire  logic        srst_i,
	// wishbone slave
	input  wire  logic        wb_cyc_i,
	input  wire  logic        wb_stb_i,
	input  wire  logic        wb_we_i,
	input  wire  logic [3:0]  wb_adr_i,
	input  wire  logic [3:0]  wb_sel_i,
	input  wire  logic [31:0] wb_dat_i,
	output logic [31:0]       wb_dat_o,
	output logic              wb_ack_o,
	// host image of stored protection and supply
	input  wire  logic        stored_prot_i,
	input  wire  logic        supply_ok_i,
	// flash bus
	output logic [21:0]       fl_addr_o,
	output logic [15:0]       fl_dq_o,
	output logic              fl_dq_oe_o,
	input  wire  logic [15:0] fl_dq_i,
	output logic              fl_ce_n_o,
	output logic              fl_we_n_o,
	output logic              fl_oe_n_o,
	output logic [1:0]        fl_reset_level_o,
	output logic [1:0]        protect_accel_pin_o,
	output logic              pwr_en_o
);
	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b000,
		ST_SEQ  = 3'b001,
		ST_CYC  = 3'b010,
		ST_DONE = 3'b011
	} fsg_state_t;

	fsg_state_t  state_reg;
	logic [7:0]  ctrl_reg;
	logic [21:0] addr_reg;
	logic [15:0] data_reg;
	logic [15:0] rdata_reg;
	logic        busy_reg;
	logic        refused_reg;
	logic        secured_reg;
	logic [7:0]  ind_reg;
	logic [1:0]  step_reg;
	logic [1:0]  nsteps_reg;
	logic [2:0]  op_reg;
	logic        start_reg;
	logic        cyc_wr;
	logic        cyc_done;
	logic        refuse;
	logic        wb_hit;
	logic        pwr_up_reg;
	logic [7:0]  sector;

	assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;

	// wishbone ack, one cycle after request
	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= wb_hit;
	end

	// read mux
	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
			wb_dat_o <= '0;
		else if (wb_hit && !wb_we_i)
		begin
			case (wb_adr_i)
				fsg_pkg::REG_CTRL:   wb_dat_o <= {24'h000000, ctrl_reg};
				fsg_pkg::REG_ADDR:   wb_dat_o <= {10'h000, addr_reg};
				fsg_pkg::REG_DATA:   wb_dat_o <= {16'h0000, rdata_reg};
				fsg_pkg::REG_STATUS: wb_dat_o <= {16'h0000, ind_reg, 5'h00,
				                                   secured_reg, refused_reg, busy_reg};
				default:             wb_dat_o <= '0;
			endcase
		end
	end

	// control register; go bit self-clears
	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
			ctrl_reg <= 8'h80;
		else if (wb_hit && wb_we_i && wb_sel_i[0] && wb_adr_i == fsg_pkg::REG_CTRL)
			ctrl_reg <= wb_dat_i[7:0];
		else
			ctrl_reg[fsg_pkg::CTRL_GO] <= 1'b0;
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			addr_reg <= '0;
			data_reg <= '0;
		end
		else if (wb_hit && wb_we_i)
		begin
			if (wb_adr_i == fsg_pkg::REG_ADDR)
				addr_reg <= wb_dat_i[21:0];
			if (wb_adr_i == fsg_pkg::REG_DATA)
				data_reg <= wb_dat_i[15:0];
		end
	end

	// pin levels: always defined, acceleration suppressed in secured mode
	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			protect_accel_pin_o <= fsg_pkg::PA_HIGH;
			fl_reset_level_o    <= fsg_pkg::RP_LOW;
			pwr_en_o            <= 1'b0;
		end
		else
		begin
			if (secured_reg && ctrl_reg[fsg_pkg::CTRL_PA_LSB +: 2] == fsg_pkg::PA_ACC)
				protect_accel_pin_o <= fsg_pkg::PA_HIGH;
			else if (ctrl_reg[fsg_pkg::CTRL_PA_LSB +: 2] == fsg_pkg::PA_ACC)
				protect_accel_pin_o <= fsg_pkg::PA_ACC;
			else
				protect_accel_pin_o <= (ctrl_reg[fsg_pkg::CTRL_PA_LSB +: 2] == fsg_pkg::PA_LOW) ?
				                       fsg_pkg::PA_LOW : fsg_pkg::PA_HIGH;
			// high voltage on reset: temporary unprotect only, no full unprotect
			fl_reset_level_o <= ctrl_reg[fsg_pkg::CTRL_HV] ? fsg_pkg::RP_HV :
			                    (ctrl_reg[fsg_pkg::CTRL_PWR] ? fsg_pkg::RP_HIGH : fsg_pkg::RP_LOW);
			pwr_en_o <= ctrl_reg[fsg_pkg::CTRL_PWR];
		end
	end

	// sector number from word address: eight small sectors at each end
	always_comb
	begin
		sector = 8'(addr_reg[21:fsg_pkg::BLK_LSB]) + 8'(fsg_pkg::BLK_BASE);
		if (addr_reg[21:fsg_pkg::BLK_LSB] == '0)
			sector = 8'(addr_reg[fsg_pkg::BLK_LSB-1:fsg_pkg::SEC_LSB]);
		else if (addr_reg[21:fsg_pkg::BLK_LSB] == '1)
			sector = 8'(fsg_pkg::TOP_BASE) + 8'(addr_reg[fsg_pkg::BLK_LSB-1:fsg_pkg::SEC_LSB]);
	end
	fsg_guard u_guard
	(
		.sector_i      (sector),
		.pa_level_i    (protect_accel_pin_o),
		.hv_reset_i    (fl_reset_level_o == fsg_pkg::RP_HV),
		.stored_prot_i (stored_prot_i),
		.secured_i     (secured_reg),
		.ind_i         (ind_reg),
		.refuse_o      (refuse)
	);

	// power-up hold: strobes idle, no cycle before supply good
	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
			pwr_up_reg <= 1'b0;
		else
			pwr_up_reg <= supply_ok_i && pwr_en_o && fl_reset_level_o != fsg_pkg::RP_LOW;
	end

	// sequencer
	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i || !pwr_up_reg)
		begin
			state_reg   <= ST_IDLE;
			busy_reg    <= 1'b0;
			step_reg    <= '0;
			nsteps_reg  <= '0;
			op_reg      <= fsg_pkg::OP_READ;
			start_reg   <= 1'b0;
			refused_reg <= 1'b0;
			secured_reg <= 1'b0;
			fl_addr_o   <= '0;
			fl_dq_o     <= '0;
			rdata_reg   <= '0;
		end
		else
		begin
			start_reg <= 1'b0;
			case (state_reg)
				ST_IDLE:
				begin
					if (ctrl_reg[fsg_pkg::CTRL_GO])
					begin
						op_reg      <= ctrl_reg[fsg_pkg::CTRL_OP_LSB +: fsg_pkg::CTRL_OP_W];
						busy_reg    <= 1'b1;
						refused_reg <= 1'b0;
						step_reg    <= '0;
						state_reg   <= ST_SEQ;
						case (ctrl_reg[fsg_pkg::CTRL_OP_LSB +: fsg_pkg::CTRL_OP_W])
							fsg_pkg::OP_PROGRAM:  nsteps_reg <= 2'h3;
							fsg_pkg::OP_SEC_ENT:  nsteps_reg <= 2'h2;
							fsg_pkg::OP_SEC_EXIT: nsteps_reg <= 2'h3;
							default:              nsteps_reg <= 2'h0;
						endcase
					end
				end
				ST_SEQ:
				begin
					start_reg <= 1'b1;
					state_reg <= ST_CYC;
					if (op_reg == fsg_pkg::OP_PROGRAM && refuse)
					begin
						// predicted refusal: abandon, send reset to read mode
						refused_reg <= 1'b1;
						nsteps_reg  <= '0;
						op_reg      <= fsg_pkg::OP_RESET;
						fl_addr_o   <= '0;
						fl_dq_o     <= fsg_pkg::CMD_RST;
					end
					else if (step_reg == 2'h0 && nsteps_reg != '0)
					begin
						fl_addr_o <= fsg_pkg::UNLOCK_A1;
						fl_dq_o   <= fsg_pkg::UNLOCK_D1;
					end
					else if (step_reg == 2'h1)
					begin
						fl_addr_o <= fsg_pkg::UNLOCK_A2;
						fl_dq_o   <= fsg_pkg::UNLOCK_D2;
					end
					else if (step_reg == 2'h2 && nsteps_reg != '0)
					begin
						fl_addr_o <= fsg_pkg::UNLOCK_A1;
						case (op_reg)
							fsg_pkg::OP_PROGRAM:  fl_dq_o <= fsg_pkg::CMD_PROG;
							fsg_pkg::OP_SEC_ENT:  fl_dq_o <= fsg_pkg::CMD_SENT;
							default:              fl_dq_o <= fsg_pkg::CMD_SEXIT;
						endcase
					end
					else
					begin
						fl_addr_o <= addr_reg;
						case (op_reg)
							fsg_pkg::OP_RESET:    fl_dq_o <= fsg_pkg::CMD_RST;
							fsg_pkg::OP_SEC_EXIT: fl_dq_o <= fsg_pkg::CMD_SEX2;
							default:              fl_dq_o <= data_reg;
						endcase
					end
				end
				ST_CYC:
				begin
					// take read data while output enable still stands
					if (!cyc_wr && !fl_oe_n_o)
						rdata_reg <= fl_dq_i;
					if (cyc_done)
					begin
						if (step_reg == nsteps_reg)
							state_reg <= ST_DONE;
						else
						begin
							step_reg  <= step_reg + 2'h1;
							state_reg <= ST_SEQ;
						end
					end
				end
				ST_DONE:
				begin
					busy_reg  <= 1'b0;
					state_reg <= ST_IDLE;
					if (op_reg == fsg_pkg::OP_SEC_ENT)
						secured_reg <= 1'b1;
					else if (op_reg == fsg_pkg::OP_SEC_EXIT)
						secured_reg <= 1'b0;
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// indicator image from the last host write to status bits 15:8
	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
			ind_reg <= fsg_pkg::IND_NONE;
		else if (wb_hit && wb_we_i && wb_sel_i[1] && wb_adr_i == fsg_pkg::REG_STATUS)
			ind_reg <= (wb_dat_i[15:8] == fsg_pkg::IND_FACTORY) ? fsg_pkg::IND_FACTORY :
			           (wb_dat_i[15:8] == fsg_pkg::IND_CUSTOMER) ? fsg_pkg::IND_CUSTOMER :
			           fsg_pkg::IND_NONE;
	end

	assign cyc_wr = (op_reg != fsg_pkg::OP_READ);

	fsg_strobe u_strobe
	(
		.sys_clk_i (sys_clk_i),
		.srst_i    (srst_i),
		.start_i   (start_reg),
		.write_i   (cyc_wr),
		.inhibit_i (!pwr_up_reg),
		.done_o    (cyc_done),
		.ce_n_o    (fl_ce_n_o),
		.we_n_o    (fl_we_n_o),
		.oe_n_o    (fl_oe_n_o),
		.dq_oe_o   (fl_dq_oe_o)
	);
endmodule // fsg_host

// File: tb/fsg_host_chk.sv
/*
 checker for fsg_host: wishbone handshake and flash strobe relations.
 assumes a bind to fsg_host, one clock, synchronous active-high reset.
*/
`timescale 1ns/1ps
module fsg_host_chk
(
	// clock and reset
	input  wire  logic       sys_clk_i,
	input  wire  logic       srst_i,
	// wishbone
	input  wire  logic       wb_cyc_i,
	input  wire  logic       wb_stb_i,
	input  wire  logic       wb_ack_o,
	// flash side
	input  wire  logic       supply_ok_i,
	input  wire  logic       fl_dq_oe_o,
	input  wire  logic       fl_ce_n_o,
	input  wire  logic       fl_we_n_o,
	input  wire  logic       fl_oe_n_o,
	input  wire  logic [1:0] protect_accel_pin_o
);
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (srst_i);

	chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered next cycle");
	chk_write_gate: assert property (!fl_we_n_o |-> !fl_ce_n_o && fl_oe_n_o)
		else $error("write strobe without chip enable or with output enable");
	chk_we_width: assert property ($fell(fl_we_n_o) |-> !fl_we_n_o [*3])
		else $error("write strobe too short");
	chk_supply_hold: assert property (!supply_ok_i [*6] |-> fl_we_n_o)
		else $error("write strobe during low supply");
	chk_pa_defined: assert property (protect_accel_pin_o != 2'h3)
		else $error("protect pin level undefined");
	chk_dq_drive: assert property (!fl_we_n_o |-> fl_dq_oe_o)
		else $error("write strobe without data drive");
	chk_no_contend: assert property (!fl_oe_n_o |-> !fl_dq_oe_o)
		else $error("data driven during read");
endmodule // fsg_host_chk

bind fsg_host fsg_host_chk u_chk
(
	.sys_clk_i           (sys_clk_i),
	.srst_i              (srst_i),
	.wb_cyc_i            (wb_cyc_i),
	.wb_stb_i            (wb_stb_i),
	.wb_ack_o            (wb_ack_o),
	.supply_ok_i         (supply_ok_i),
	.fl_dq_oe_o          (fl_dq_oe_o),
	.fl_ce_n_o           (fl_ce_n_o),
	.fl_we_n_o           (fl_we_n_o),
	.fl_oe_n_o           (fl_oe_n_o),
	.protect_accel_pin_o (protect_accel_pin_o)
);

// File: tb/fsg_flash_model.sv
/*
 behavioural protected flash: unlock decoding, boot protection, secured mode.
 assumes the host holds address and data until the write strobe rises.
*/
`timescale 1ns/1ps
module fsg_flash_model
#(
	parameter logic [15:0] SEC_WORD = 16'hc3c3
)
(
	// bus
	input  wire  logic        ce_n_i,
	input  wire  logic        we_n_i,
	input  wire  logic        oe_n_i,
	input  wire  logic [21:0] addr_i,
	input  wire  logic [15:0] dq_i,
	output logic [15:0]       dq_o,
	// levels
	input  wire  logic [1:0]  pa_i,
	input  wire  logic [1:0]  rst_i,
	input  wire  logic        stored_i,
	input  wire  logic        supply_i
);
	logic [15:0] mem [16];
	logic [2:0]  step;
	logic        sec;
	int          nw;
	wire         boot = addr_i[21:13] == 9'h000 || addr_i[21:13] == 9'h1ff;
	wire         prot = (boot && pa_i == fsg_pkg::PA_LOW)
		|| (stored_i && rst_i != fsg_pkg::RP_HV);
	wire         live = supply_i && rst_i != fsg_pkg::RP_LOW;
	wire         wr_on = !ce_n_i && !we_n_i && oe_n_i && live;
	realtime     t_on;
	// read data, inverse when not driven
	wire  [15:0] rd = (sec && boot) ? SEC_WORD : mem[addr_i[3:0]];
	assign dq_o = (!ce_n_i && !oe_n_i) ? rd : ~rd;

	initial
	begin
		step = 3'h0;
		sec = 1'b0;
		nw = 0;
		t_on = 0.0;
		for (int i = 0; i < 16; i++)
			mem[i] = 16'h0000;
	end

	always @(supply_i, rst_i)
	begin
		if (!live)
		begin
			step = 3'h0;
			sec = 1'b0;
		end
	end

	always @(posedge wr_on)
		t_on = $realtime;

	// a write ends on the first of ce or we rising; short pulses are noise
	always @(negedge wr_on)
	begin
		if (live && $realtime - t_on >= fsg_pkg::GLITCH_NS)
		begin
			nw++;
			if (step == 3'h3)
			begin
				if (!prot && !(sec && pa_i == fsg_pkg::PA_ACC))
					mem[addr_i[3:0]] = dq_i;
				step = 3'h0;
			end
			else if (dq_i == fsg_pkg::UNLOCK_D1 && addr_i == fsg_pkg::UNLOCK_A1)
				step = 3'h1;
			else if (step == 3'h1 && dq_i == fsg_pkg::UNLOCK_D2)
				step = 3'h2;
			else if (step == 3'h2 && dq_i == fsg_pkg::CMD_PROG)
				step = 3'h3;
			else if (step == 3'h2 && dq_i == fsg_pkg::CMD_SENT)
			begin
				sec = 1'b1;
				step = 3'h0;
			end
			else if (step == 3'h2 && dq_i == fsg_pkg::CMD_SEXIT)
				step = 3'h4;
			else
			begin
				if (step == 3'h4)
					sec = 1'b0;
				step = 3'h0;
			end
		end
	end
endmodule // fsg_flash_model

// File: tb/test_fsg_host.sv
/*
 self-checking bench for fsg_host with a behavioural flash.
 assumes a 50 MHz clock and wishbone answers within a few cycles.
*/
`timescale 1ns/1ps
`define CHK(a, b) \
	begin \
		n_checks++; \
		if ((a) !== (b)) \
		begin \
			mismatches++; \
			$display("unexpected at %0t: got %h want %h", $time, (a), (b)); \
		end \
	end
module test_fsg_host;
	logic        clk;
	logic        srst;
	logic        cyc;
	logic        stb;
	logic        we;
	logic [3:0]  adr;
	logic [31:0] wdat;
	logic [31:0] rdat;
	logic        ack;
	logic        sprot;
	logic        sok;
	logic [21:0] fa;
	logic [15:0] fdo;
	logic [15:0] fdi;
	logic        fdoe;
	logic        ce_n;
	logic        we_n;
	logic        oe_n;
	logic [1:0]  rlvl;
	logic [1:0]  pa;
	logic        pwr_en;
	int          mismatches = 0;
	int          n_checks = 0;

	fsg_host dut
	(
		.sys_clk_i (clk), .srst_i (srst), .wb_cyc_i (cyc), .wb_stb_i (stb),
		.wb_we_i (we), .wb_adr_i (adr), .wb_sel_i (4'hf), .wb_dat_i (wdat),
		.wb_dat_o (rdat), .wb_ack_o (ack), .stored_prot_i (sprot), .supply_ok_i (sok),
		.fl_addr_o (fa), .fl_dq_o (fdo), .fl_dq_oe_o (fdoe), .fl_dq_i (fdi),
		.fl_ce_n_o (ce_n), .fl_we_n_o (we_n), .fl_oe_n_o (oe_n),
		.fl_reset_level_o (rlvl), .protect_accel_pin_o (pa), .pwr_en_o (pwr_en)
	);
	fsg_flash_model u_fl
	(
		.ce_n_i (ce_n), .we_n_i (we_n), .oe_n_i (oe_n), .addr_i (fa), .dq_i (fdo),
		.dq_o (fdi), .pa_i (pa), .rst_i (rlvl), .stored_i (sprot), .supply_i (sok)
	);

	always #10 clk = ~clk;

	task automatic report_and_stop();
		if (mismatches == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic wbx(input logic w, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (ack !== 1'b1 && n < 40);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 40)
			mismatches++;
	endtask

	task automatic run(input logic [2:0] op, input logic [1:0] p, input logic h,
		output logic [31:0] st);
		int n;
		n = 0;
		wbx(1'b1, fsg_pkg::REG_CTRL, {24'h0, 1'b1, h, p, op, 1'b1}, st);
		do
		begin
			wbx(1'b0, fsg_pkg::REG_STATUS, 32'h0, st);
			n++;
		end
		while (st[fsg_pkg::ST_BUSY] !== 1'b0 && n < 60);
		if (n >= 60)
			mismatches++;
	endtask

	task automatic t_regs();
		logic [31:0] q;
		wbx(1'b0, fsg_pkg::REG_CTRL, 32'h0, q);
		`CHK(q, 32'h0000_0080)
		`CHK(pwr_en, 1'b1)
		wbx(1'b1, 4'h2, 32'hffff_ffff, q);
		wbx(1'b0, 4'h2, 32'h0, q);
		`CHK(q, 32'h0000_0000)
	endtask

	task automatic t_prot();
		logic [21:0] ta [8] = '{22'h000001, 22'h3fe002, 22'h001003, 22'h3ff004,
			22'h3ff005, 22'h000006, 22'h100007, 22'h100008};
		logic [1:0]  tp [8] = '{fsg_pkg::PA_LOW, fsg_pkg::PA_LOW, fsg_pkg::PA_HIGH,
			fsg_pkg::PA_HIGH, fsg_pkg::PA_HIGH, fsg_pkg::PA_LOW, fsg_pkg::PA_HIGH,
			fsg_pkg::PA_ACC};
		logic [7:0]  th = 8'b0011_0000;
		logic [7:0]  tk = 8'b0111_1000;
		logic [7:0]  tr = 8'b0110_1011;
		logic [31:0] q;
		for (int i = 0; i < 8; i++)
		begin
			@(posedge clk);
			sprot <= tk[i];
			wbx(1'b1, fsg_pkg::REG_ADDR, {10'h0, ta[i]}, q);
			wbx(1'b1, fsg_pkg::REG_DATA, 32'h1000 + i, q);
			run(fsg_pkg::OP_PROGRAM, tp[i], th[i], q);
			`CHK(q[fsg_pkg::ST_REFUSED], tr[i])
			`CHK(u_fl.mem[ta[i][3:0]], tr[i] ? 16'h0 : 16'h1000 + i)
			`CHK(pa, tp[i])
			`CHK(rlvl, th[i] ? fsg_pkg::RP_HV : fsg_pkg::RP_HIGH)
		end
		wbx(1'b1, fsg_pkg::REG_ADDR, {10'h0, ta[2]}, q);
		run(fsg_pkg::OP_READ, fsg_pkg::PA_HIGH, 1'b0, q);
		wbx(1'b0, fsg_pkg::REG_DATA, 32'h0, q);
		`CHK(q[15:0], 16'h1002)
	endtask

	task automatic t_sec();
		logic [7:0]  v [3] = '{8'h81, 8'h41, 8'h07};
		logic [7:0]  e [3] = '{8'h81, 8'h41, 8'h01};
		logic [31:0] q;
		run(fsg_pkg::OP_SEC_ENT, fsg_pkg::PA_HIGH, 1'b0, q);
		`CHK(q[fsg_pkg::ST_SEC], 1'b1)
		wbx(1'b1, fsg_pkg::REG_ADDR, 32'h0, q);
		run(fsg_pkg::OP_READ, fsg_pkg::PA_ACC, 1'b0, q);
		`CHK(pa, fsg_pkg::PA_HIGH)
		wbx(1'b0, fsg_pkg::REG_DATA, 32'h0, q);
		`CHK(q[15:0], 16'hc3c3)
		for (int i = 0; i < 3; i++)
		begin
			wbx(1'b1, fsg_pkg::REG_STATUS, {16'h0, v[i], 8'h0}, q);
			wbx(1'b0, fsg_pkg::REG_STATUS, 32'h0, q);
			`CHK(q[15:8], e[i])
		end
		for (int i = 0; i < 2; i++)
		begin
			wbx(1'b1, fsg_pkg::REG_STATUS, {16'h0, e[i], 8'h0}, q);
			run(fsg_pkg::OP_PROGRAM, fsg_pkg::PA_HIGH, 1'b0, q);
			`CHK(q[fsg_pkg::ST_REFUSED], 1'b1)
			`CHK(q[fsg_pkg::ST_SEC], 1'b1)
			`CHK(u_fl.mem[0], 16'h0000)
		end
		run(fsg_pkg::OP_SEC_EXIT, fsg_pkg::PA_HIGH, 1'b0, q);
		`CHK(q[fsg_pkg::ST_SEC], 1'b0)
		run(fsg_pkg::OP_READ, fsg_pkg::PA_HIGH, 1'b0, q);
		wbx(1'b0, fsg_pkg::REG_DATA, 32'h0, q);
		`CHK(q[15:0], 16'h0000)
	endtask

	task automatic t_supply();
		int          n0;
		logic [31:0] q;
		n0 = u_fl.nw;
		@(posedge clk);
		sok <= 1'b0;
		wbx(1'b1, fsg_pkg::REG_ADDR, 32'h0010_000a, q);
		wbx(1'b1, fsg_pkg::REG_DATA, 32'h5555, q);
		run(fsg_pkg::OP_PROGRAM, fsg_pkg::PA_HIGH, 1'b0, q);
		`CHK(u_fl.nw, n0)
		`CHK(u_fl.mem[10], 16'h0000)
		@(posedge clk);
		sok <= 1'b1;
	endtask

	task automatic t_hwreset();
		logic [31:0] q;
		run(fsg_pkg::OP_SEC_ENT, fsg_pkg::PA_HIGH, 1'b0, q);
		@(posedge clk);
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		wbx(1'b0, fsg_pkg::REG_STATUS, 32'h0, q);
		`CHK(q[fsg_pkg::ST_SEC], 1'b0)
		`CHK(u_fl.sec, 1'b0)
	endtask

	initial
	begin
		#400000;
		mismatches++;
		report_and_stop();
	end

	initial
	begin
		clk = 1'b0;
		srst = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 4'h0;
		wdat = 32'h0;
		sprot = 1'b0;
		sok = 1'b1;
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		t_regs();
		t_prot();
		t_sec();
		t_supply();
		t_hwreset();
		report_and_stop();
	end
endmodule // test_fsg_host
